// File: rtl/motor_serial_pkg.sv
package motor_serial_pkg;

  // ==========================================================
  // timing
  localparam int REF_NS        = 100;
  localparam int DEGLITCH_NS   = 5000;
  localparam int CLEAR_MAX_NS  = 20000;
  localparam int GAP_NS        = 500;
  localparam int WAKE_NS       = 1000;
  localparam int PULSE_NS      = 10000;
  localparam int DEGLITCH_CYC  = (DEGLITCH_NS + REF_NS - 1) / REF_NS;
  localparam int CLEAR_MAX_CYC = CLEAR_MAX_NS / REF_NS;
  localparam int GAP_CYC       = (GAP_NS + REF_NS - 1) / REF_NS;
  localparam int WAKE_CYC      = (WAKE_NS + REF_NS - 1) / REF_NS;
  localparam int PULSE_CYC     = (PULSE_NS + REF_NS - 1) / REF_NS;
  localparam int HALF_CYC      = 4;

  // ==========================================================
  // frame layout
  localparam logic [1:0] TOP_STATUS   = 2'h3;
  localparam logic [1:0] TOP_HEADER   = 2'h2;
  localparam int         RW_BIT       = 6;
  localparam int         HDR_CLR_BIT  = 5;
  localparam logic [7:0] SINGLE_LAST  = 8'h01;

  // ==========================================================
  // register map
  localparam logic [4:0]  ADDR_FAULT  = 5'h00;
  localparam logic [4:0]  ADDR_DIAG   = 5'h01;
  localparam logic [4:0]  ADDR_CTRL_LO = 5'h02;
  localparam logic [4:0]  ADDR_CTRL_HI = 5'h05;
  localparam logic [4:0]  ADDR_CLR    = 5'h04;
  localparam logic [1:0]  CTRL_BASE   = 2'h2;
  localparam int          CLR_BIT     = 7;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0051;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_LOW  = 3'h1,
    H_HIGH = 3'h2,
    H_END  = 3'h3,
    H_GAP  = 3'h4
  } host_state_t;

endpackage

// File: rtl/motor_serial_if.sv
`timescale 1ns/100ps
interface motor_serial_if;
  logic serialClk;
  logic frameSelectN;
  logic hostData;
  logic devData;
  logic devDataOe;
  logic lowPowerRequestN;

  modport device (
    input  serialClk,
    input  frameSelectN,
    input  hostData,
    input  lowPowerRequestN,
    output devData,
    output devDataOe
  );

  modport host (
    output serialClk,
    output frameSelectN,
    output hostData,
    output lowPowerRequestN,
    input  devData,
    input  devDataOe
  );
endinterface

// File: rtl/motor_serial_device.sv
// Behaviour
// [RULE1] disable high puts both bridges Hi-Z
// [RULE2] serial port keeps working while disabled
// [RULE3] active only awake, enabled, supply ok, waked
// [RULE4] 5 to 20 us sleep pulse clears faults
// [RULE5] sleep pulse clears flags, pump untouched
// [RULE6] input word: 0, rw, address, x, data
// [RULE7] output word: 11, six flags, report
// [RULE8] report is register contents before write
// [RULE9] host keeps clock low at select edges
// [RULE10] host keeps select high 500 ns
// [RULE11] deselected: ignore clock, output Hi-Z
// [RULE12] sample falling, drive rising, MSB first
// [RULE13] not 16 clocks: frame error, discard
// [RULE14] only selected device takes part
// [RULE15] chain: headers, addresses, data bytes
// [RULE16] chain returns statuses, headers, reports
// [RULE17] header bytes start with one, zero
// [RULE18] six bit chain length, max 63
// [RULE19] header clear command clears at select rise
// [RULE20] second header low bits passed through
// [RULE21] chain status byte: 11 and flags
// [RULE22] position from status count, load own bytes
// [RULE23] chain address, data bytes as single frame
// [RULE24] writes only on valid frame at select rise
`timescale 1ns/100ps
module motor_serial_device (
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  motor_serial_if.device     link,
  input  wire logic [5:0]    faultIn,
  input  wire logic [7:0]    diagIn,
  input  wire logic          disableIn,
  input  wire logic          supplyOkIn,
  output logic               bridgeHiZ,
  output logic               pumpEnable,
  output logic               activeMode,
  output logic               frameError,
  output logic [31:0]        controlRegs
);
  import motor_serial_pkg::*;

  // ==========================================================
  // link side, falling edge: receive and parse
  logic        sleepMode;
  logic        linkRst;
  logic        frameRst;
  logic [2:0]  bitCnt;
  logic [7:0]  byteCnt;
  logic [6:0]  rxSh;
  logic        isChain;
  logic        seenHdr;
  logic [5:0]  pos;
  logic [5:0]  chainLen;
  logic        clrReq;
  logic        done;
  logic        over;
  logic [7:0]  lastByte;
  logic [7:0]  addrByte;
  logic [4:0]  holdAddr;
  logic [7:0]  holdData;
  logic        holdWrite;
  logic        holdClr;
  logic        commitTgl;
  logic        abortTgl;

  assign linkRst  = sys_rst | sleepMode;
  // [RULE11] select high clears frame state
  // [RULE14] own select gates everything but the link-side flag copy
  assign frameRst = linkRst | link.frameSelectN;

  wire [7:0] rxByte   = {rxSh, link.hostData};
  wire       byteEnd  = (bitCnt == 3'h7);
  wire [1:0] rxTop    = rxByte[7:6];
  wire [7:0] lenWide  = {2'h0, chainLen};
  wire [7:0] addrIdx  = isChain ? lenWide + 8'h01 : 8'h00;
  wire [7:0] lastIdx  = isChain ? {1'b0, chainLen, 1'b1} : SINGLE_LAST;
  wire [7:0] hdr2Idx  = {2'h0, pos} + 8'h01;
  wire       isFinal  = byteEnd && (byteCnt == lastIdx)
                        && (!isChain || seenHdr);
  wire       isAddr   = byteEnd && (byteCnt == addrIdx)
                        && (!isChain || seenHdr);

  // [RULE12] capture on the falling edge, MSB first
  always_ff @(negedge link.serialClk or posedge frameRst) begin
    if (frameRst) begin
      bitCnt   <= 3'h0;
      byteCnt  <= 8'h00;
      rxSh     <= 7'h00;
      lastByte <= 8'h00;
      addrByte <= 8'h00;
      done     <= 1'b0;
      over     <= 1'b0;
    end else begin
      bitCnt <= bitCnt + 3'h1;
      rxSh   <= rxByte[6:0];
      if (byteEnd) begin
        lastByte <= rxByte;
        if (byteCnt != 8'hFF) begin
          byteCnt <= byteCnt + 8'h01;
        end
      end
      // [RULE23] same address byte encoding in both modes
      if (isAddr) begin
        addrByte <= rxByte;
      end
      if (isFinal) begin
        done <= 1'b1;
      end
      if (done) begin
        over <= 1'b1;
      end
    end
  end

  // [RULE22] count status bytes, then take length
  always_ff @(negedge link.serialClk or posedge frameRst) begin
    if (frameRst) begin
      isChain  <= 1'b0;
      seenHdr  <= 1'b0;
      pos      <= 6'h00;
      chainLen <= 6'h00;
      clrReq   <= 1'b0;
    end else if (byteEnd) begin
      if (byteCnt == 8'h00) begin
        isChain <= rxByte[7];
      end
      if (!seenHdr && (byteCnt == 8'h00 || isChain)) begin
        if (rxTop == TOP_STATUS) begin
          pos <= pos + 6'h01;
        end else if (rxTop == TOP_HEADER) begin
          seenHdr  <= 1'b1;
          // [RULE18] six bit device count
          chainLen <= rxByte[5:0];
        end
      end else if (seenHdr && byteCnt == hdr2Idx) begin
        // [RULE20] bit 5 of the second header is taken as the clear request
        clrReq <= rxByte[HDR_CLR_BIT];
      end
    end
  end

  // [RULE13] completion and overrun reported by toggles
  always_ff @(negedge link.serialClk or posedge linkRst) begin
    if (linkRst) begin
      holdAddr  <= 5'h00;
      holdData  <= 8'h00;
      holdWrite <= 1'b0;
      holdClr   <= 1'b0;
      commitTgl <= 1'b0;
      abortTgl  <= 1'b0;
    end else if (!link.frameSelectN) begin
      if (isFinal && !done) begin
        // address byte is captured in both modes
        holdAddr  <= addrByte[5:1];
        holdWrite <= !addrByte[RW_BIT];
        holdData  <= rxByte;
        holdClr   <= isChain & clrReq;
        commitTgl <= ~commitTgl;
      end
      if (done && !over) begin
        abortTgl <= ~abortTgl;
      end
    end
  end

  // ==========================================================
  // link side, rising edge: transmit
  logic [5:0] fltL1;
  logic [5:0] fltL2;
  logic [7:0] txSh;
  logic [7:0] rdVal;
  logic [5:0] faultReg;
  logic [7:0] diagS;
  logic [3:0][7:0] ctrlReg;

  // control registers only change at select rise, so they stand still here
  wire [4:0] rdAddr   = addrByte[5:1];
  wire       rdCtrl   = rdAddr >= ADDR_CTRL_LO && rdAddr <= ADDR_CTRL_HI;
  wire [1:0] ctrlIdx  = rdAddr[1:0] - CTRL_BASE;
  // flags move at any time, so read the link-side copy
  wire [7:0] faultRd  = {1'b0, |fltL2, fltL2};
  assign rdVal = (rdAddr == ADDR_FAULT) ? faultRd :
                 (rdAddr == ADDR_DIAG)  ? diagS :
                 rdCtrl ? ctrlReg[ctrlIdx] : 8'h00;

  wire [7:0] reportSlot = lenWide + 8'h02;
  wire       isReport   = isChain ? (seenHdr && byteCnt == reportSlot)
                                  : (byteCnt == SINGLE_LAST);
  // [RULE7] status byte then report byte
  // [RULE21] leading status byte carries 11 and flags
  // [RULE16] reports replace own slot, rest delayed a byte
  wire [7:0] txLoad = (byteCnt == 8'h00) ? {TOP_STATUS, fltL2} :
                      isReport ? rdVal : lastByte;

  always_ff @(posedge link.serialClk or posedge linkRst) begin
    if (linkRst) begin
      fltL1 <= 6'h00;
      fltL2 <= 6'h00;
    end else begin
      fltL1 <= faultReg;
      fltL2 <= fltL1;
    end
  end

  // [RULE12] drive on the rising edge
  always_ff @(posedge link.serialClk or posedge frameRst) begin
    if (frameRst) begin
      txSh          <= 8'h00;
      link.devData   <= 1'b0;
      link.devDataOe <= 1'b0;
    end else begin
      link.devDataOe <= 1'b1;
      if (bitCnt == 3'h0) begin
        // [RULE8] report taken before any write lands
        link.devData <= txLoad[7];
        txSh         <= {txLoad[6:0], 1'b0};
      end else begin
        link.devData <= txSh[7];
        txSh         <= {txSh[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // reference side: synchronisers
  logic [2:0] csSy;
  logic [2:0] cmSy;
  logic [2:0] abSy;
  logic [2:0] slSy;
  logic [1:0] disSy;
  logic [1:0] supSy;
  logic [5:0] fltS1;
  logic [5:0] fltS;
  logic [7:0] diagS1;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      csSy   <= 3'h7;
      cmSy   <= 3'h0;
      abSy   <= 3'h0;
      slSy   <= 3'h0;
      disSy  <= 2'h0;
      supSy  <= 2'h0;
      fltS1  <= 6'h00;
      fltS   <= 6'h00;
      diagS1 <= 8'h00;
      diagS  <= 8'h00;
    end else begin
      csSy   <= {csSy[1:0], link.frameSelectN};
      cmSy   <= {cmSy[1:0], commitTgl};
      abSy   <= {abSy[1:0], abortTgl};
      slSy   <= {slSy[1:0], link.lowPowerRequestN};
      disSy  <= {disSy[0], disableIn};
      supSy  <= {supSy[0], supplyOkIn};
      fltS1  <= faultIn;
      fltS   <= fltS1;
      diagS1 <= diagIn;
      diagS  <= diagS1;
    end
  end

  // ==========================================================
  // reference side: frame commit, faults, modes
  logic       pend;
  logic       bad;
  logic [7:0] lowCnt;
  logic [7:0] wakeCnt;

  wire cmEdge  = cmSy[2] ^ cmSy[1];
  wire abEdge  = abSy[2] ^ abSy[1];
  wire csRise  = csSy[1] & ~csSy[2];
  wire slRise  = slSy[1] & ~slSy[2];
  wire goodFrm = csRise & (pend | cmEdge) & ~(bad | abEdge);
  wire wrHit   = goodFrm & holdWrite
                 & holdAddr >= ADDR_CTRL_LO & holdAddr <= ADDR_CTRL_HI;
  wire [1:0] wrIdx = holdAddr[1:0] - CTRL_BASE;
  wire regClr  = wrHit & (holdAddr == ADDR_CLR) & holdData[CLR_BIT];
  // [RULE4] pulse past the deglitch time clears
  wire slClr   = slRise & (lowCnt >= 8'(DEGLITCH_CYC));
  // [RULE19] header clear acts at select rise
  wire fltClr  = regClr | slClr | (goodFrm & holdClr);
  // [RULE3] awake, enabled and supply good
  wire runOk   = slSy[1] & ~disSy[1] & supSy[1];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend        <= 1'b0;
      bad         <= 1'b0;
      frameError  <= 1'b0;
      ctrlReg     <= CTRL_RST;
      faultReg    <= 6'h00;
    end else begin
      pend <= csRise ? 1'b0 : (pend | cmEdge);
      bad  <= csRise ? 1'b0 : (bad | abEdge);
      // [RULE13] short or long frame raises the error
      if (csRise) begin
        frameError <= ~goodFrm;
      end
      // [RULE24] write lands only for a good frame
      if (wrHit) begin
        ctrlReg[wrIdx] <= holdData;
        if (holdAddr == ADDR_CLR) begin
          ctrlReg[wrIdx][CLR_BIT] <= 1'b0;
        end
      end
      // [RULE5] new fault wins over a clear
      faultReg <= (faultReg & ~{6{fltClr}}) | fltS;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowCnt      <= 8'h00;
      sleepMode   <= 1'b1;
      wakeCnt     <= 8'h00;
      activeMode  <= 1'b0;
      bridgeHiZ   <= 1'b1;
      pumpEnable  <= 1'b0;
      controlRegs <= CTRL_RST;
    end else begin
      if (slSy[1]) begin
        lowCnt <= 8'h00;
      end else if (lowCnt != 8'hFF) begin
        lowCnt <= lowCnt + 8'h01;
      end
      // a pulse up to the clear window keeps the port alive
      sleepMode <= ~slSy[1] & (lowCnt >= 8'(CLEAR_MAX_CYC));
      if (!runOk) begin
        wakeCnt <= 8'h00;
      end else if (wakeCnt != 8'(WAKE_CYC)) begin
        wakeCnt <= wakeCnt + 8'h01;
      end
      activeMode  <= runOk & (wakeCnt == 8'(WAKE_CYC));
      // [RULE1] disabled bridge stays Hi-Z
      bridgeHiZ   <= ~(runOk & (wakeCnt == 8'(WAKE_CYC)));
      // [RULE2] serial side ignores disable entirely
      // a clear pulse must not drop the pump, only real sleep or a low supply does
      pumpEnable  <= ~sleepMode & supSy[1];
      controlRegs <= ctrlReg;
    end
  end

endmodule

// File: rtl/motor_serial_host.sv
`timescale 1ns/100ps
module motor_serial_host (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  motor_serial_if.host     link,
  input  wire logic        reqValid,
  input  wire logic [7:0]  reqByte,
  input  wire logic        reqLast,
  output logic             reqReady,
  output logic [7:0]       rspByte,
  output logic             rspValid,
  output logic             busy,
  input  wire logic        sleepReq,
  input  wire logic        clearPulse
);
  import motor_serial_pkg::*;

  // ==========================================================
  // frame engine
  host_state_t state;
  logic [7:0]  cnt;
  logic [2:0]  bitCnt;
  logic        needByte;
  logic        curLast;
  logic [7:0]  txSh;
  logic [6:0]  rxSh;
  logic [1:0]  misoSy;
  logic [7:0]  pulseCnt;

  wire take     = reqValid & reqReady;
  wire halfDone = (cnt == 8'(HALF_CYC - 1));
  wire [7:0] rxByte = {rxSh, misoSy[1]};

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      misoSy <= 2'h0;
    end else begin
      misoSy <= {misoSy[0], link.devData};
    end
  end

  // [RULE9] clock is low at both select edges
  // [RULE12] drive on rise, sample on fall, MSB first
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state             <= H_IDLE;
      cnt               <= 8'h00;
      bitCnt            <= 3'h0;
      needByte          <= 1'b0;
      curLast           <= 1'b0;
      txSh              <= 8'h00;
      rxSh              <= 7'h00;
      reqReady          <= 1'b0;
      rspByte           <= 8'h00;
      rspValid          <= 1'b0;
      busy              <= 1'b0;
      link.serialClk    <= 1'b0;
      link.frameSelectN <= 1'b1;
      link.hostData     <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      busy     <= (state != H_IDLE);
      case (state)
        H_IDLE: begin
          reqReady <= ~take;
          if (take) begin
            // [RULE14] this select line alone opens the frame
            link.frameSelectN <= 1'b0;
            txSh              <= reqByte;
            curLast           <= reqLast;
            cnt               <= 8'h00;
            bitCnt            <= 3'h0;
            needByte          <= 1'b0;
            state             <= H_LOW;
          end
        end
        H_LOW: begin
          if (needByte) begin
            // clock parks low while the source stalls
            if (take) begin
              txSh     <= reqByte;
              curLast  <= reqLast;
              needByte <= 1'b0;
              reqReady <= 1'b0;
            end
          end else if (halfDone) begin
            link.serialClk <= 1'b1;
            link.hostData  <= txSh[7];
            txSh           <= {txSh[6:0], 1'b0};
            cnt            <= 8'h00;
            state          <= H_HIGH;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        H_HIGH: begin
          if (halfDone) begin
            link.serialClk <= 1'b0;
            rxSh           <= rxByte[6:0];
            bitCnt         <= bitCnt + 3'h1;
            cnt            <= 8'h00;
            state          <= H_LOW;
            if (bitCnt == 3'h7) begin
              rspByte  <= rxByte;
              rspValid <= 1'b1;
              // [RULE15] caller streams the whole chain frame
              if (curLast) begin
                state <= H_END;
              end else begin
                needByte <= 1'b1;
                reqReady <= 1'b1;
              end
            end
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        H_END: begin
          if (halfDone) begin
            link.frameSelectN <= 1'b1;
            cnt               <= 8'h00;
            state             <= H_GAP;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        H_GAP: begin
          // [RULE10] select held high between frames
          if (cnt == 8'(GAP_CYC - 1)) begin
            state <= H_IDLE;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // sleep line
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulseCnt              <= 8'h00;
      link.lowPowerRequestN <= 1'b0;
    end else begin
      // [RULE4] clear pulse sits inside the 5 to 20 us window
      if (clearPulse) begin
        pulseCnt <= 8'(PULSE_CYC);
      end else if (pulseCnt != 8'h00) begin
        pulseCnt <= pulseCnt - 8'h01;
      end
      link.lowPowerRequestN <= ~(sleepReq | clearPulse
                                 | (pulseCnt > 8'h01));
    end
  end

endmodule

// File: tb/motor_serial_chk.sv
`timescale 1ns/100ps
module motor_serial_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic serialClk,
  input wire logic frameSelectN,
  input wire logic hostData,
  input wire logic devData,
  input wire logic devDataOe,
  input wire logic lowPowerRequestN
);
  // ==========================================================
  // helper counters
  logic [9:0] bitCnt;
  logic [7:0] lowCnt;

  // select high clears at once, so a stray edge never counts
  always_ff @(negedge serialClk or posedge frameSelectN) begin
    if (frameSelectN) begin
      bitCnt <= 10'h000;
    end else begin
      bitCnt <= bitCnt + 10'h001;
    end
  end

  // saturates so a long sleep cannot wrap into the window
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lowCnt <= 8'h00;
    end else if (lowPowerRequestN) begin
      lowCnt <= 8'h00;
    end else if (lowCnt != 8'hFF) begin
      lowCnt <= lowCnt + 8'h01;
    end
  end

  // ==========================================================
  // link assertions
  a_sclk_low_open: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $fell(frameSelectN) |-> !serialClk) else $error("clock high at select fall");
  a_sclk_low_close: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(frameSelectN) |-> !serialClk) else $error("clock high at select rise");
  a_select_gap: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(frameSelectN) |-> frameSelectN [*5]) else $error("select gap short");
  a_clock_parked: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    frameSelectN |-> !serialClk) else $error("clock runs while deselected");
  a_idle_released: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    frameSelectN [*2] |-> !devDataOe) else $error("output driven while idle");
  a_oe_in_frame: assert property (
    @(negedge serialClk) disable iff (sys_rst)
    !frameSelectN |-> devDataOe) else $error("output not driven at sample");
  a_status_lead: assert property (
    @(negedge serialClk) disable iff (sys_rst)
    (bitCnt < 10'h002) |-> devData) else $error("status lead bits not ones");
  a_dev_shift_rise: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (devDataOe && $past(devDataOe) && $changed(devData)) |-> $rose(serialClk))
    else $error("device data changed off rising clock");
  a_host_shift_rise: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    (!frameSelectN && $past(!frameSelectN) && $changed(hostData))
    |-> $rose(serialClk)) else $error("host data changed off rising clock");
  a_whole_bytes: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(frameSelectN) |-> ($past(bitCnt[2:0]) == 3'h0 &&
    $past(bitCnt) != 10'h000)) else $error("frame not whole bytes");
  a_pulse_window: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    ($rose(lowPowerRequestN) && lowCnt > 8'h03)
    |-> (lowCnt > 8'h32 && lowCnt < 8'hC8)) else $error("sleep pulse width");
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import motor_serial_pkg::*;
  // ==========================================================
  // signals and ends
  logic        ref_clk, sys_rst, reqValid, reqLast, reqReady, rspValid;
  logic        busy, sleepReq, clearPulse, disableIn, supplyOkIn;
  logic        bridgeHiZ, pumpEnable, activeMode, frameError;
  logic [7:0]  reqByte, rspByte, diagIn;
  logic [5:0]  faultIn;
  logic [31:0] controlRegs;
  logic [7:0]  tx [4];
  logic [7:0]  rx [4];
  int          nErrors;
  int          numChecks;

  motor_serial_if motor_serial_if_i ();
  motor_serial_host motor_serial_host_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .link(motor_serial_if_i.host), .reqValid(reqValid),
    .reqByte(reqByte), .reqLast(reqLast), .reqReady(reqReady),
    .rspByte(rspByte), .rspValid(rspValid), .busy(busy),
    .sleepReq(sleepReq), .clearPulse(clearPulse));
  motor_serial_device motor_serial_device_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .link(motor_serial_if_i.device), .faultIn(faultIn),
    .diagIn(diagIn), .disableIn(disableIn), .supplyOkIn(supplyOkIn),
    .bridgeHiZ(bridgeHiZ), .pumpEnable(pumpEnable),
    .activeMode(activeMode), .frameError(frameError),
    .controlRegs(controlRegs));
  motor_serial_chk motor_serial_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .serialClk(motor_serial_if_i.serialClk),
    .frameSelectN(motor_serial_if_i.frameSelectN),
    .hostData(motor_serial_if_i.hostData),
    .devData(motor_serial_if_i.devData),
    .devDataOe(motor_serial_if_i.devDataOe),
    .lowPowerRequestN(motor_serial_if_i.lowPowerRequestN));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // shared tasks
  task automatic giveVerdict();
    if (nErrors == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [7:0] cmd(input logic rw, input logic [4:0] a);
    return {1'b0, rw, a, 1'b0};
  endfunction

  // one byte at a time: offer, wait for the take, then for its answer
  task automatic runFrame(input int n);
    int t;
    for (int k = 0; k < n; k++) begin
      reqByte = tx[k];
      reqLast = (k == n - 1);
      reqValid = 1'b1;
      t = 0;
      do begin
        @(negedge ref_clk);
        t++;
      end while (reqReady !== 1'b1 && t < 300);
      tick(1);
      reqValid = 1'b0;
      do begin
        @(negedge ref_clk);
        t++;
      end while (rspValid !== 1'b1 && t < 600);
      rx[k] = rspByte;
      tick(1);
    end
    while (busy !== 1'b0 && t < 900) begin
      @(negedge ref_clk);
      t++;
    end
    check("frame done", 8'h00, {7'h00, busy});
    tick(12);
  endtask

  task automatic frame2(input logic [7:0] b0, input logic [7:0] b1);
    tx[0] = b0;
    tx[1] = b1;
    runFrame(2);
  endtask

  // ==========================================================
  // scenarios
  task automatic scReset();
    check("reg reset", 8'h51, controlRegs[7:0]);
    check("hiz reset", 8'h01, {7'h00, bridgeHiZ});
    check("oe reset", 8'h00, {7'h00, motor_serial_if_i.devDataOe});
  endtask

  task automatic scWriteDisabled();
    frame2(cmd(1'b0, ADDR_CTRL_LO), 8'hAA);
    check("write status", 8'hC0, rx[0]);
    check("write report", 8'h51, rx[1]);
    check("write commit", 8'hAA, controlRegs[7:0]);
    check("disabled hiz", 8'h01, {7'h00, bridgeHiZ});
  endtask

  task automatic scRead();
    frame2(cmd(1'b1, ADDR_CTRL_LO), 8'h00);
    check("read ctrl", 8'hAA, rx[1]);
    frame2(cmd(1'b0, ADDR_DIAG), 8'hFF);
    check("diag write report", 8'h5A, rx[1]);
    frame2(cmd(1'b1, ADDR_DIAG), 8'h00);
    check("diag read only", 8'h5A, rx[1]);
    frame2(cmd(1'b1, 5'h06), 8'h00);
    check("reserved read", 8'h00, rx[1]);
  endtask

  task automatic scFrameError();
    tx[0] = cmd(1'b0, ADDR_CTRL_LO);
    tx[1] = 8'h33;
    tx[2] = 8'h00;
    runFrame(3);
    check("long frame", 8'h01, {7'h00, frameError});
    check("long ignored", 8'hAA, controlRegs[7:0]);
    runFrame(1);
    check("short frame", 8'h01, {7'h00, frameError});
    frame2(cmd(1'b1, ADDR_CTRL_LO), 8'h00);
    check("good frame", 8'h00, {7'h00, frameError});
    check("reg kept", 8'hAA, rx[1]);
  endtask

  task automatic scActive();
    disableIn = 1'b0;
    tick(WAKE_CYC + 10);
    check("active", 8'h01, {7'h00, activeMode});
    check("bridge on", 8'h00, {7'h00, bridgeHiZ});
    supplyOkIn = 1'b0;
    tick(10);
    check("supply low", 8'h00, {7'h00, activeMode});
    supplyOkIn = 1'b1;
    tick(WAKE_CYC + 10);
  endtask

  task automatic scFaults();
    faultIn = 6'h24;
    tick(10);
    faultIn = 6'h00;
    frame2(cmd(1'b1, ADDR_FAULT), 8'h00);
    frame2(cmd(1'b1, ADDR_FAULT), 8'h00);
    check("fault status", 8'hE4, rx[0]);
    check("fault reg", 8'h64, rx[1]);
    clearPulse = 1'b1;
    tick(1);
    clearPulse = 1'b0;
    tick(50);
    check("pump in pulse", 8'h01, {7'h00, pumpEnable});
    tick(PULSE_CYC - 30);
    check("pump kept", 8'h01, {7'h00, pumpEnable});
    frame2(cmd(1'b1, ADDR_FAULT), 8'h00);
    frame2(cmd(1'b1, ADDR_FAULT), 8'h00);
    check("pulse clear", 8'hC0, rx[0]);
    check("reg clear", 8'h00, rx[1]);
  endtask

  // one device chained: headers pass through behind its own status
  task automatic scChain();
    faultIn = 6'h03;
    tick(10);
    faultIn = 6'h00;
    frame2(cmd(1'b1, ADDR_FAULT), 8'h00);
    tx[0] = 8'h81;
    tx[1] = 8'hB5;
    tx[2] = cmd(1'b0, 5'h03);
    tx[3] = 8'h3C;
    runFrame(4);
    check("chain status", 8'hC3, rx[0]);
    check("chain header1", 8'h81, rx[1]);
    check("chain header2", 8'hB5, rx[2]);
    check("chain report", 8'h00, rx[3]);
    check("chain write", 8'h3C, controlRegs[15:8]);
    frame2(cmd(1'b1, ADDR_FAULT), 8'h00);
    frame2(cmd(1'b1, ADDR_FAULT), 8'h00);
    check("chain clear", 8'hC0, rx[0]);
    faultIn = 6'h10;
    tick(10);
    faultIn = 6'h00;
    frame2(cmd(1'b0, ADDR_CLR), 8'h80);
    check("clear self", 8'h00, controlRegs[23:16]);
    frame2(cmd(1'b1, ADDR_FAULT), 8'h00);
    check("reg bit clear", 8'h00, rx[1]);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    reqValid = 1'b0;
    reqByte = 8'h00;
    reqLast = 1'b0;
    sleepReq = 1'b0;
    clearPulse = 1'b0;
    faultIn = 6'h00;
    diagIn = 8'h5A;
    disableIn = 1'b1;
    supplyOkIn = 1'b1;
    nErrors = 0;
    numChecks = 0;
    tick(2);
    sys_rst = 1'b0;
    scReset();
    tick(20);
    scWriteDisabled();
    scRead();
    scFrameError();
    scActive();
    scFaults();
    scChain();
    giveVerdict();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    nErrors++;
    giveVerdict();
  end
endmodule
